//--- inc/core_ops_pkg.sv
// constants for the compare and core launch execution block
//
// Overview of operation
// - compare-subtract: opcode 111000, four cycles
// - subtract when dest >= source, write if selected
// - zero on equal, carry on dest >= source
// - source is register or 9-bit immediate
// - signed extended compare 110001, four cycles, no write
// - signed: zero chained, carry on multi-word less
// - unsigned extended compare 110011, four cycles, no write
// - unsigned: zero chained, carry on multi-word less
// - read core id writes 0-7, zero if id 0
// - hub instructions take seven to 22 cycles
// - launch core: opcode 000011, source code 010
// - launch word: pointer, code address, new, id
// - pointer lands in pointer register bits 15:2
// - load $000-$1EF, clear specials, run at $000
// - new bit set: lowest inactive core started
// - new bit clear: named core (re)started
// - zero on id 0, carry when none free
// - result is started or would-be core id
// - false condition: four-cycle no-op, no changes
package core_ops_pkg;
  // -------------------------------------------------------------------
  // instruction word layout
  // -------------------------------------------------------------------
  localparam int OPC_HI  = 31;
  localparam int OPC_LO  = 26;
  localparam int EFF_WZ  = 25;
  localparam int EFF_WC  = 24;
  localparam int EFF_WR  = 23;
  localparam int EFF_IMM = 22;
  localparam int CON_HI  = 21;
  localparam int CON_LO  = 18;
  localparam int DST_HI  = 17;
  localparam int DST_LO  = 9;
  localparam int SRC_HI  = 8;
  localparam int SRC_LO  = 0;

  // -------------------------------------------------------------------
  // opcodes and hub sub-codes
  // -------------------------------------------------------------------
  localparam logic [5:0] OPC_CMP_PLAIN = 6'h21;
  localparam logic [5:0] OPC_CMP_SUB   = 6'h38;
  localparam logic [5:0] OPC_CMP_SX    = 6'h31;
  localparam logic [5:0] OPC_CMP_X     = 6'h33;
  localparam logic [5:0] OPC_HUB       = 6'h03;
  localparam logic [2:0] HUB_READ_ID   = 3'h1;
  localparam logic [2:0] HUB_LAUNCH    = 3'h2;

  // -------------------------------------------------------------------
  // launch word fields
  // -------------------------------------------------------------------
  localparam int LW_PAR_HI  = 31;
  localparam int LW_PAR_LO  = 18;
  localparam int LW_CODE_HI = 17;
  localparam int LW_CODE_LO = 4;
  localparam int LW_NEW     = 3;
  localparam int LW_ID_HI   = 2;
  localparam int LW_ID_LO   = 0;

  // -------------------------------------------------------------------
  // timing, in sys_clk cycles
  // -------------------------------------------------------------------
  localparam logic [4:0] ALU_CYC     = 5'h04;
  localparam logic [4:0] HUB_MIN_CYC = 5'h07;
  localparam logic [4:0] HUB_MAX_CYC = 5'h16;

  // -------------------------------------------------------------------
  // core register file regions
  // -------------------------------------------------------------------
  localparam logic [8:0] LOAD_FIRST = 9'h000;
  localparam logic [8:0] LOAD_LAST  = 9'h1ef;
  localparam logic [8:0] SPR_FIRST  = 9'h1f0;
  localparam logic [8:0] SPR_LAST   = 9'h1ff;

  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [2:0]  CORE_ID_RST = 3'h0;
  localparam logic [15:0] PAR_RST     = 16'h0000;
endpackage

//--- inc/launch_load_if.sv
// carrier between executor and launch loader
`timescale 1ns/1ps
`default_nettype none
interface launch_load_if;
  logic        start;
  logic [13:0] codeAddr;
  logic [13:0] parPtr;
  logic        busy;
  modport ctrl   (output start, output codeAddr, output parPtr, input busy);
  modport loader (input start, input codeAddr, input parPtr, output busy);
endinterface
`default_nettype wire

//--- logic/launch_loader.sv
// loads core registers from main memory when this core is launched
`timescale 1ns/1ps
`default_nettype none
module launch_loader
  import core_ops_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // request from the top
  launch_load_if.loader    ld,
  // main memory read port
  output logic             memReq,
  output logic [15:0]      memAddr,
  input  wire logic        memAck,
  input  wire logic [31:0] memData,
  // core register write port
  output logic             regWe,
  output logic [8:0]       regAddr,
  output logic [31:0]      regData,
  // run control
  output logic [15:0]      parameterPointerReg,
  output logic             runStart
);
  typedef enum logic [1:0] {L_IDLE, L_READ, L_CLEAR, L_GO} load_state_t;

  load_state_t stQ, stD;
  logic [8:0]  idxQ, idxD;
  logic [13:0] baseQ, baseD;
  logic [15:0] parQ, parD;
  logic        weQ, weD;
  logic [8:0]  waQ, waD;
  logic [31:0] wdQ, wdD;
  logic        goQ, goD;

  // -------------------------------------------------------------------
  // sequencing
  // -------------------------------------------------------------------
  always_comb begin
    stD   = stQ;
    idxD  = idxQ;
    baseD = baseQ;
    parD  = parQ;
    weD   = 1'b0;
    waD   = waQ;
    wdD   = wdQ;
    goD   = 1'b0;
    case (stQ)
      L_IDLE: begin
        if (ld.start) begin
          stD   = L_READ;
          idxD  = LOAD_FIRST;
          baseD = ld.codeAddr;
          parD  = {ld.parPtr, 2'h0};
        end
      end
      L_READ: begin
        if (memAck) begin
          weD = 1'b1;
          waD = idxQ;
          wdD = memData;
          if (idxQ == LOAD_LAST) begin
            stD  = L_CLEAR;
            idxD = SPR_FIRST;
          end else begin
            idxD = idxQ + 9'h001;
          end
        end
      end
      L_CLEAR: begin
        weD = 1'b1;
        waD = idxQ;
        wdD = 32'h0000_0000;
        if (idxQ == SPR_LAST) begin
          stD = L_GO;
        end else begin
          idxD = idxQ + 9'h001;
        end
      end
      L_GO: begin
        goD = 1'b1;
        stD = L_IDLE;
      end
      default: stD = L_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stQ   <= L_IDLE;
      idxQ  <= 9'h000;
      baseQ <= 14'h0000;
      parQ  <= PAR_RST;
      weQ   <= 1'b0;
      waQ   <= 9'h000;
      wdQ   <= 32'h0000_0000;
      goQ   <= 1'b0;
    end else begin
      stQ   <= stD;
      idxQ  <= idxD;
      baseQ <= baseD;
      parQ  <= parD;
      weQ   <= weD;
      waQ   <= waD;
      wdQ   <= wdD;
      goQ   <= goD;
    end
  end

  // word address is base plus index, in bytes
  assign memReq              = (stQ == L_READ);
  assign memAddr             = {baseQ + {5'h00, idxQ}, 2'h0};
  assign regWe               = weQ;
  assign regAddr             = waQ;
  assign regData             = wdQ;
  assign parameterPointerReg = parQ;
  assign runStart            = goQ;
  assign ld.busy             = (stQ != L_IDLE);
endmodule
`default_nettype wire

//--- logic/compare_core_exec.sv
// executes compare and hub core-control instructions
`timescale 1ns/1ps
`default_nettype none
module compare_core_exec
  import core_ops_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // instruction issue
  input  wire logic        execStart,
  input  wire logic [31:0] instrWord,
  input  wire logic [31:0] dstValue,
  input  wire logic [31:0] srcRegValue,
  output logic             execBusy,
  output logic             execDone,
  // results
  output logic             resultWe,
  output logic [8:0]       resultAddr,
  output logic [31:0]      resultValue,
  output logic             flagZero,
  output logic             flagCarry,
  // core identity strap
  input  wire logic [2:0]  coreIdStrap,
  // hub access and launch request
  input  wire logic        hubWindow,
  output logic             launchReq,
  output logic             launchNew,
  output logic [2:0]       launchTarget,
  output logic [13:0]      launchCode,
  output logic [13:0]      launchPar,
  input  wire logic [2:0]  hubChosenId,
  input  wire logic        hubNoneFree,
  // incoming launch of this core
  input  wire logic        launchIn,
  input  wire logic [13:0] launchInCode,
  input  wire logic [13:0] launchInPar,
  output logic             loadBusy,
  // main memory read port
  output logic             memReq,
  output logic [15:0]      memAddr,
  input  wire logic        memAck,
  input  wire logic [31:0] memData,
  // core register write port and run control
  output logic             regWe,
  output logic [8:0]       regAddr,
  output logic [31:0]      regData,
  output logic [15:0]      parameterPointerReg,
  output logic             runStart
);
  import core_ops_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ALU, S_HUB} exec_state_t;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  exec_state_t stQ, stD;
  logic [4:0]  cntQ, cntD;
  logic [31:0] insQ, insD;
  logic [31:0] dQ, dD;
  logic [31:0] sQ, sD;
  logic        skipQ, skipD;
  logic        seenQ, seenD;
  logic [2:0]  hubIdQ, hubIdD;
  logic        noneQ, noneD;
  logic        zQ, zD;
  logic        cQ, cD;
  logic        weQ, weD;
  logic [8:0]  waQ, waD;
  logic [31:0] wvQ, wvD;
  logic        doneQ, doneD;
  logic [2:0]  idQ;
  logic        strapDoneQ;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  logic [5:0]  opc;
  logic        effZ;
  logic        effC;
  logic        effR;
  logic        condOk;
  logic [2:0]  hubSub;
  logic        isHub;
  logic [32:0] uDiff;
  logic [33:0] sDiff;
  logic        uBorrow;
  logic        sBorrow;
  logic        eqX;
  logic        lastCyc;

  assign opc    = insQ[OPC_HI:OPC_LO];
  assign effZ   = insQ[EFF_WZ];
  assign effC   = insQ[EFF_WC];
  assign effR   = insQ[EFF_WR];
  assign hubSub = insQ[2:0];
  assign isHub  = (instrWord[OPC_HI:OPC_LO] == OPC_HUB);

  // extended compares subtract the carry as well
  assign uDiff   = {1'b0, dQ} - {1'b0, sQ} - {32'h0000_0000, cQ};
  assign sDiff   = {dQ[31], dQ[31], dQ} - {sQ[31], sQ[31], sQ}
                   - {33'h0_0000_0000, cQ};
  assign uBorrow = uDiff[32];
  assign sBorrow = sDiff[33];
  assign eqX     = (uDiff[31:0] == 32'h0000_0000);
  assign lastCyc = (cntQ == ALU_CYC - 5'h01);

  // -------------------------------------------------------------------
  // capture the core identity after reset release
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      idQ        <= CORE_ID_RST;
      strapDoneQ <= 1'b0;
    end else if (!strapDoneQ) begin
      idQ        <= coreIdStrap;
      strapDoneQ <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // condition check on issue
  // -------------------------------------------------------------------
  always_comb begin
    condOk = instrWord[CON_LO + {30'h0, cQ, zQ}];
  end

  // -------------------------------------------------------------------
  // execution
  // -------------------------------------------------------------------
  always_comb begin
    stD    = stQ;
    cntD   = cntQ;
    insD   = insQ;
    dD     = dQ;
    sD     = sQ;
    skipD  = skipQ;
    seenD  = seenQ;
    hubIdD = hubIdQ;
    noneD  = noneQ;
    zD     = zQ;
    cD     = cQ;
    weD    = 1'b0;
    waD    = waQ;
    wvD    = wvQ;
    doneD  = 1'b0;
    case (stQ)
      S_IDLE: begin
        if (execStart) begin
          insD  = instrWord;
          dD    = dstValue;
          sD    = instrWord[EFF_IMM]
                  ? {23'h00_0000, instrWord[SRC_HI:SRC_LO]}
                  : srcRegValue;
          skipD = !condOk;
          seenD = 1'b0;
          cntD  = 5'h01;
          stD   = (isHub && condOk) ? S_HUB : S_ALU;
        end
      end
      S_ALU: begin
        cntD = cntQ + 5'h01;
        if (lastCyc) begin
          stD   = S_IDLE;
          doneD = 1'b1;
          waD   = insQ[DST_HI:DST_LO];
          if (!skipQ) begin
            case (opc)
              OPC_CMP_SUB: begin
                if (effZ) zD = (dQ == sQ);
                if (effC) cD = (dQ >= sQ);
                if (effR && (dQ >= sQ)) begin
                  weD = 1'b1;
                  wvD = dQ - sQ;
                end
              end
              OPC_CMP_PLAIN: begin
                if (effZ) zD = (dQ == sQ);
                if (effC) cD = (dQ < sQ);
              end
              OPC_CMP_X: begin
                if (effZ) zD = zQ && eqX;
                if (effC) cD = uBorrow;
              end
              OPC_CMP_SX: begin
                if (effZ) zD = zQ && eqX;
                if (effC) cD = sBorrow;
              end
              default: ;
            endcase
          end
        end
      end
      S_HUB: begin
        if (cntQ != HUB_MAX_CYC) begin
          cntD = cntQ + 5'h01;
        end
        if (hubWindow && !seenQ) begin
          seenD  = 1'b1;
          hubIdD = hubChosenId;
          noneD  = hubNoneFree;
        end
        if (seenQ && cntQ >= HUB_MIN_CYC - 5'h01) begin
          stD   = S_IDLE;
          doneD = 1'b1;
          waD   = insQ[DST_HI:DST_LO];
          case (hubSub)
            HUB_READ_ID: begin
              if (effZ) zD = (idQ == 3'h0);
              if (effR) begin
                weD = 1'b1;
                wvD = {29'h0000_0000, idQ};
              end
            end
            HUB_LAUNCH: begin
              if (effZ) zD = (hubIdQ == 3'h0);
              if (effC) cD = noneQ;
              if (effR) begin
                weD = 1'b1;
                wvD = {29'h0000_0000, hubIdQ};
              end
            end
            default: ;
          endcase
        end
      end
      default: stD = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stQ    <= S_IDLE;
      cntQ   <= 5'h00;
      insQ   <= 32'h0000_0000;
      dQ     <= 32'h0000_0000;
      sQ     <= 32'h0000_0000;
      skipQ  <= 1'b0;
      seenQ  <= 1'b0;
      hubIdQ <= 3'h0;
      noneQ  <= 1'b0;
      zQ     <= 1'b0;
      cQ     <= 1'b0;
      weQ    <= 1'b0;
      waQ    <= 9'h000;
      wvQ    <= 32'h0000_0000;
      doneQ  <= 1'b0;
    end else begin
      stQ    <= stD;
      cntQ   <= cntD;
      insQ   <= insD;
      dQ     <= dD;
      sQ     <= sD;
      skipQ  <= skipD;
      seenQ  <= seenD;
      hubIdQ <= hubIdD;
      noneQ  <= noneD;
      zQ     <= zD;
      cQ     <= cD;
      weQ    <= weD;
      waQ    <= waD;
      wvQ    <= wvD;
      doneQ  <= doneD;
    end
  end

  // -------------------------------------------------------------------
  // launch request towards the hub
  // -------------------------------------------------------------------
  assign launchReq    = (stQ == S_HUB) && !seenQ
                        && (hubSub == HUB_LAUNCH);
  assign launchNew    = dQ[LW_NEW];
  assign launchTarget = dQ[LW_ID_HI:LW_ID_LO];
  assign launchCode   = dQ[LW_CODE_HI:LW_CODE_LO];
  assign launchPar    = dQ[LW_PAR_HI:LW_PAR_LO];

  // -------------------------------------------------------------------
  // loader for launches that target this core
  // -------------------------------------------------------------------
  launch_load_if ldIf ();

  assign ldIf.start    = launchIn && !ldIf.busy;
  assign ldIf.codeAddr = launchInCode;
  assign ldIf.parPtr   = launchInPar;
  assign loadBusy      = ldIf.busy;

  launch_loader u_loader (
    .sys_clk             (sys_clk),
    .reset_n             (reset_n),
    .ld                  (ldIf.loader),
    .memReq              (memReq),
    .memAddr             (memAddr),
    .memAck              (memAck),
    .memData             (memData),
    .regWe               (regWe),
    .regAddr             (regAddr),
    .regData             (regData),
    .parameterPointerReg (parameterPointerReg),
    .runStart            (runStart)
  );

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign execBusy    = (stQ != S_IDLE);
  assign execDone    = doneQ;
  assign resultWe    = weQ;
  assign resultAddr  = waQ;
  assign resultValue = wvQ;
  assign flagZero    = zQ;
  assign flagCarry   = cQ;
endmodule
`default_nettype wire

//--- sim/hub_partner.sv
// hub arbiter and main memory model facing the executor
`timescale 1ns/1ps
`default_nettype none
module hub_partner #(
  parameter logic [7:0] ACT_INIT = 8'h05
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // hub slot and launch
  input  wire logic [2:0]  selfId,
  input  wire logic        launchReq,
  input  wire logic        launchNew,
  input  wire logic [2:0]  launchTarget,
  input  wire logic [13:0] launchCode,
  input  wire logic [13:0] launchPar,
  output logic             hubWindow,
  output logic [2:0]       hubChosenId,
  output logic             hubNoneFree,
  output logic             launchIn,
  output logic [13:0]      launchInCode,
  output logic [13:0]      launchInPar,
  // main memory
  input  wire logic        memReq,
  input  wire logic [15:0] memAddr,
  output logic             memAck,
  output logic [31:0]      memData
);
  logic [7:0] act;
  logic [3:0] slot;
  logic [2:0] low;
  always_comb begin
    low = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (!act[i]) low = 3'(i);
    end
  end
  assign hubWindow = slot == 4'h0;
  assign hubChosenId = launchNew ? low : launchTarget;
  assign hubNoneFree = launchNew && act == 8'hff;
  // idle bus shows a moving pattern, never the last word
  assign memData = memAck ? {memAddr, ~memAddr} : {8{slot}};
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      act <= ACT_INIT;
      slot <= 4'h9;
      memAck <= 1'b0;
      launchIn <= 1'b0;
      launchInCode <= 14'h0;
      launchInPar <= 14'h0;
    end else begin
      slot <= slot + 4'h1;
      // stall one slot in four
      memAck <= memReq && !memAck && slot[1:0] != 2'h3;
      launchIn <= 1'b0;
      if (hubWindow && launchReq && !hubNoneFree) begin
        act[hubChosenId] <= 1'b1;
        launchIn <= hubChosenId == selfId;
        launchInCode <= launchCode;
        launchInPar <= launchPar;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/compare_core_exec_assertions.sv
// port-level checks for the executor
`timescale 1ns/1ps
`default_nettype none
module compare_core_exec_assertions
  import core_ops_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // issue and results
  input wire logic        execStart,
  input wire logic [31:0] instrWord,
  input wire logic [31:0] dstValue,
  input wire logic        execBusy,
  input wire logic        execDone,
  input wire logic        resultWe,
  input wire logic [8:0]  resultAddr,
  input wire logic        flagZero,
  input wire logic        flagCarry,
  // launch and loader
  input wire logic        launchReq,
  input wire logic        launchNew,
  input wire logic [2:0]  launchTarget,
  input wire logic [13:0] launchCode,
  input wire logic [13:0] launchPar,
  input wire logic        memReq,
  input wire logic [15:0] memAddr,
  input wire logic        memAck,
  input wire logic        regWe,
  input wire logic [8:0]  regAddr,
  input wire logic [31:0] regData
);
  logic [31:0] insQ;
  logic [31:0] dstQ;
  logic        take;
  logic        condOk;
  logic        hubOp;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  assign take = execStart && !execBusy;
  assign condOk = instrWord[CON_LO + {flagCarry, flagZero}];
  assign hubOp = instrWord[OPC_HI:OPC_LO] == OPC_HUB &&
                 (instrWord[SRC_HI:SRC_LO] == 9'(HUB_READ_ID) ||
                  instrWord[SRC_HI:SRC_LO] == 9'(HUB_LAUNCH));
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      insQ <= 32'h0;
      dstQ <= 32'h0;
    end else if (take) begin
      insQ <= instrWord;
      dstQ <= dstValue;
    end
  end
  alu_four_cycles_a: assert property (
    take && (instrWord[OPC_HI:OPC_LO] != OPC_HUB || !condOk) |->
    ##1 (execBusy && !execDone)[*3] ##1 execDone)
    else $error("short instruction not done in four cycles");
  hub_early_a: assert property (
    take && hubOp && condOk |-> ##1 (!execDone)[*6])
    else $error("hub instruction done too early");
  hub_late_a: assert property (
    take && hubOp && condOk |-> ##[7:22] execDone)
    else $error("hub instruction done too late");
  flags_on_done_a: assert property (
    $changed(flagZero) || $changed(flagCarry) |-> execDone)
    else $error("flag moved outside completion");
  write_on_done_a: assert property (
    resultWe |-> execDone && insQ[EFF_WR] &&
    resultAddr == insQ[DST_HI:DST_LO])
    else $error("result write without cause");
  launch_fields_a: assert property (
    launchReq |-> {launchPar, launchCode, launchNew, launchTarget} == dstQ)
    else $error("launch fields differ from destination word");
  mem_hold_a: assert property (
    memReq && !memAck |=> memReq && $stable(memAddr))
    else $error("memory request dropped before answer");
  spr_clear_a: assert property (
    regWe && regAddr >= SPR_FIRST |-> regData == 32'h0)
    else $error("special register not cleared");
endmodule
bind compare_core_exec compare_core_exec_assertions chk (
  .sys_clk, .reset_n, .execStart, .instrWord, .dstValue, .execBusy,
  .execDone, .resultWe, .resultAddr, .flagZero, .flagCarry, .launchReq,
  .launchNew, .launchTarget, .launchCode, .launchPar, .memReq, .memAddr,
  .memAck, .regWe, .regAddr, .regData
);
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the compare and core launch executor
`timescale 1ns/1ps
`default_nettype none
module tb;
  import core_ops_pkg::*;
  // ----------
  // signals
  // ----------
  typedef struct packed {
    logic        we;
    logic [31:0] v;
    logic        z;
    logic        c;
  } res_t;
  logic        sys_clk, reset_n, execStart, execBusy, execDone, resultWe;
  logic        flagZero, flagCarry, hubWindow, launchReq, launchNew;
  logic        hubNoneFree, launchIn, loadBusy, memReq, memAck, regWe;
  logic        runStart, zm, cm;
  logic [2:0]  coreIdStrap, launchTarget, hubChosenId;
  logic [8:0]  resultAddr, regAddr;
  logic [13:0] launchCode, launchPar, launchInCode, launchInPar;
  logic [13:0] ldCode, ldPar;
  logic [15:0] memAddr, parameterPointerReg;
  logic [31:0] instrWord, dstValue, srcRegValue, resultValue, memData;
  logic [31:0] regData, rng;
  logic [7:0]  act;
  int          errTotal, totalChecks, li, runs;
  res_t        expq[$];
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  compare_core_exec uut (.*);
  hub_partner #(.ACT_INIT(8'h05)) hub (.selfId(coreIdStrap), .*);
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] nx(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic fail(input string m);
    errTotal++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic ok, input string m);
    totalChecks++;
    if (ok !== 1'b1) fail(m);
  endtask
  task automatic cmpRes(input res_t e);
    totalChecks++;
    if (resultWe !== e.we || flagZero !== e.z || flagCarry !== e.c ||
        (e.we && resultValue !== e.v)) fail("execution result");
  endtask
  task automatic cmpReg(input int i);
    logic [15:0] a;
    a = 16'((ldCode + 16'(i)) << 2);
    totalChecks++;
    if (regAddr !== 9'(i) || regData !== (i < 496 ? {a, ~a} : 32'h0))
      fail("register load");
  endtask
  task automatic reportAndStop();
    if (errTotal == 0 && totalChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // issue one instruction, note its expected result, wait for completion
  task automatic op(input logic [5:0] o, input logic [3:0] e,
                    input logic [3:0] cn, input logic [8:0] sf,
                    input logic [31:0] d, input logic [31:0] sr);
    logic [31:0] sv;
    logic [33:0] t, u;
    logic [2:0]  id;
    logic        go, hb, nf;
    res_t        x;
    int          n;
    rng = nx(rng);
    sv = e[0] ? {23'h0, sf} : sr;
    go = cn[{cm, zm}];
    hb = go && o == OPC_HUB;
    x = '{1'b0, 32'h0, zm, cm};
    t = {{2{d[31]}}, d} - {{2{sv[31]}}, sv} - 34'(cm);
    u = {2'h0, d} - {2'h0, sv} - 34'(cm);
    if (go) begin
      case (o)
        OPC_CMP_PLAIN: x = '{1'b0, 32'h0, d == sv, d < sv};
        OPC_CMP_SUB: x = '{e[1] && d >= sv, d - sv, d == sv, d >= sv};
        OPC_CMP_X: x = '{1'b0, 32'h0, zm && u[31:0] == 0, u[33]};
        OPC_CMP_SX: x = '{1'b0, 32'h0, zm && t[31:0] == 0, t[33]};
        OPC_HUB: begin
          id = d[3] ? 3'h0 : d[2:0];
          for (int i = 7; i >= 0; i--) if (d[3] && !act[i]) id = 3'(i);
          nf = d[3] && act == 8'hff;
          if (sf == 9'(HUB_READ_ID)) id = coreIdStrap;
          else if (!nf) act[id] = 1'b1;
          x = '{e[1], {29'h0, id}, id == 3'h0, nf};
        end
        default: ;
      endcase
    end
    if (e[3]) zm = x.z;
    if (e[2]) cm = x.c;
    x.z = zm;
    x.c = cm;
    expq.push_back(x);
    instrWord = {o, e, cn, rng[8:0], sf};
    dstValue = d;
    srcRegValue = sr;
    execStart = 1'b1;
    @(posedge sys_clk);
    n = 0;
    do begin
      @(negedge sys_clk);
      if (n == 0) execStart = 1'b0;
      n++;
    end while (execDone !== 1'b1 && n < 40);
    chk(hb ? n > 6 && n < 23 : n == 4, "length");
  endtask
  task automatic doReset(input logic [2:0] s);
    @(negedge sys_clk);
    reset_n = 1'b0;
    coreIdStrap = s;
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    zm = 1'b0;
    cm = 1'b0;
    act = 8'h05;
    runs = 0;
    repeat (2) @(negedge sys_clk);
  endtask
  // ----------
  // monitor
  // ----------
  always @(negedge sys_clk) begin
    if (execDone === 1'b1) begin
      if (expq.size() == 0) fail("unexpected completion");
      else cmpRes(expq.pop_front());
    end
    if (launchIn === 1'b1 && loadBusy === 1'b0) begin
      li = 0;
      ldCode = launchInCode;
      ldPar = launchInPar;
    end
    if (regWe === 1'b1) begin
      cmpReg(li);
      li++;
    end
    if (runStart === 1'b1) begin
      runs++;
      chk(li == 512, "start count");
      chk(parameterPointerReg === {ldPar, 2'h0}, "pointer");
    end
  end
  // ----------
  // stimulus
  // ----------
  initial begin
    logic [5:0]  opt [5];
    logic [31:0] r, d;
    logic [95:0] a, b;
    logic [8:0]  ln;
    rng = 32'h3458;
    reset_n = 1'b0;
    execStart = 1'b0;
    instrWord = 32'h0;
    dstValue = 32'h0;
    srcRegValue = 32'h0;
    coreIdStrap = 3'h6;
    errTotal = 0;
    totalChecks = 0;
    opt = '{OPC_CMP_PLAIN, OPC_CMP_SUB, OPC_CMP_SX, OPC_CMP_X, 6'h15};
    ln = 9'(HUB_LAUNCH);
    for (int p = 0; p < 2; p++) begin
      doReset(p == 0 ? 3'h6 : 3'h0);
      for (int k = 0; k < 60; k++) begin
        rng = nx(rng);
        r = rng;
        rng = nx(rng);
        d = r[9] ? rng : {23'h0, rng[8:0]};
        op(opt[k % 5], r[28:25], r[20] ? 4'hf : r[24:21],
           d[8:0] ^ {7'h0, r[11:10]}, d, r[13] ? r : d ^ {30'h0, r[11:10]});
      end
      for (int k = 0; k < 8; k++) begin
        rng = nx(rng);
        a = {rng, nx(rng), ~rng};
        b = k % 4 == 0 ? a : k % 4 == 1 ? a + 1 : k % 4 == 2 ? a - 1 :
            {~a[95:64], a[63:0]};
        op(OPC_CMP_PLAIN, 4'hc, 4'hf, 9'h0, a[31:0], b[31:0]);
        op(OPC_CMP_X, 4'hc, 4'hf, 9'h0, a[63:32], b[63:32]);
        op(OPC_CMP_SX, 4'hc, 4'hf, 9'h0, a[95:64], b[95:64]);
        chk(flagCarry === ($signed(a) < $signed(b)), "wide less");
        chk(flagZero === (a == b), "wide equal");
      end
      op(OPC_HUB, 4'ha, 4'hf, 9'(HUB_READ_ID), rng, 32'h0);
      op(OPC_HUB, 4'h8, 4'hf, 9'(HUB_READ_ID), rng, 32'h0);
      for (int k = 0; k < 7; k++) begin
        rng = nx(rng);
        op(OPC_HUB, 4'he, 4'hf, ln, {rng[31:4], 4'h8}, 32'h0);
      end
      op(OPC_HUB, 4'he, 4'h0, ln, {rng[31:4], 4'h0}, 32'h0);
      op(OPC_HUB, 4'he, 4'hf, ln, {rng[31:4], 4'h0}, 32'h0);
      op(OPC_HUB, 4'hc, 4'hf, ln, 32'(coreIdStrap), 32'h0);
      for (int k = 0; k < 4000 && (loadBusy !== 1'b0 || runs == 0); k++)
        @(negedge sys_clk);
      chk(runs == 1, "one load run");
    end
    reportAndStop();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    fail("watchdog expired");
    reportAndStop();
  end
endmodule
`default_nettype wire
